/* File: verilog/phy_vendor_status_regs.sv */
// Vendor management registers of a 10/100 Ethernet PHY: mode, symbol
// error tally, crossover control, polarity, interrupt flags and status.
// Assumes a management frame decoder that gives one-cycle read and write
// strobes with a five-bit register index, all in the sys_clk domain.
//
// Functional notes
// - Modes 000 and 001 force 10BASE-T, no autonegotiation, half or full.
// - Modes 010 and 011 force 100BASE-TX; carrier on transmit only in half.
// - Mode 100 autonegotiates advertising 100 half only, carrier both ways.
// - Mode 101 is repeater, autonegotiating 100 half, carrier on receive.
// - Mode 111 is all capable, advertising all four abilities.
// - Tally counts invalid 100BASE-TX symbols, idle ones included.
// - Tally advances at most once per received packet.
// - Tally rolls over to zero after its top value.
// - Tally resets to zero, survives reads, frozen in 10BASE-T.
// - Override clear lets the strap choose automatic crossover.
// - With override, bit 14 picks automatic or manual crossover.
// - Manual crossover: bit 13 swaps transmit and receive pair directions.
// - Bit 4 shows 10BASE-T receive polarity, one means reversed.
// - Flag bits 7 to 1 latch their seven events; bit 0 reserved.
// - Mask bits 7 to 1 enable matching flags; reset to zero.
// - Bit 12 reads one only when autonegotiation has finished.
// - Bits 4:2 show the resolved speed and duplex code.
// - Mode field sits at bits 7:5, reset value 111.
`timescale 1ns/10ps
`default_nettype none
module phy_vendor_status_regs #(
	parameter int TALLY_WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] mgmt_index,
	input wire logic mgmt_write,
	input wire logic mgmt_read,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire logic crossover_strap,
	input wire logic symbol_invalid,
	input wire logic in_packet,
	input wire logic rx_polarity_reversed,
	input wire logic [7:1] flag_events,
	input wire logic aneg_done,
	input wire logic [2:0] resolved_speed_duplex,
	output logic [2:0] ctrl_default,
	output logic [3:0] adv_default,
	output logic aneg_enable,
	output logic crs_on_tx,
	output logic repeater,
	output logic ten_base,
	output logic auto_crossover,
	output logic transmit_pair_oe,
	output logic receive_pair_oe,
	output logic irq
);
	logic [2:0] mode;
	logic [4:0] phy_addr;
	logic [15:13] xover;
	logic strap_q;
	logic [7:1] flags;
	logic [7:1] mask;
	logic [6:0] keep_bits;
	logic [15:0] tally;
	logic [15:0] next_rdata;
	logic [7:1] next_flags;
	logic [7:1] next_mask;
	logic rd_flags;
	logic wr_modes;
	logic wr_ind;
	logic wr_mask;
	logic wr_status;

	phy_mode_if mode_bus ();

	generate
		if (TALLY_WIDTH != 16) begin : g_bad_tally
			$error("phy_vendor_status_regs: tally register is 16 bits.");
		end
	endgenerate

	// ****************************************************************
	// Submodules
	// ****************************************************************
	assign mode_bus.mode = mode;

	phy_mode_decode u_decode (
		.cfg(mode_bus.decoder)
	);

	phy_bad_symbol_counter #(
		.WIDTH(TALLY_WIDTH)
	) u_tally (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.symbol_invalid(symbol_invalid),
		.in_packet(in_packet),
		.ten_base(mode_bus.ten_base),
		.tally(tally)
	);

	// ****************************************************************
	// Write decode
	// ****************************************************************
	// Register strobes; an unmapped index is simply ignored.
	assign wr_modes = mgmt_write && mgmt_index == phy_regs_pkg::IDX_SPECIAL_MODES;
	assign wr_ind = mgmt_write && mgmt_index == phy_regs_pkg::IDX_SPECIAL_IND;
	assign wr_mask = mgmt_write && mgmt_index == phy_regs_pkg::IDX_MASK;
	assign wr_status = mgmt_write &&
		mgmt_index == phy_regs_pkg::IDX_SPECIAL_STATUS;
	assign rd_flags = mgmt_read && mgmt_index == phy_regs_pkg::IDX_FLAGS;

	// Mode and address field; the decoder follows the stored mode.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode <= phy_regs_pkg::MODE_RESET;
			phy_addr <= phy_regs_pkg::PHY_ADDR_RESET;
		end else if (wr_modes) begin
			mode <= mgmt_wdata[phy_regs_pkg::MODE_MSB:phy_regs_pkg::MODE_LSB];
			phy_addr <= mgmt_wdata[4:0];
		end
	end

	// Crossover control bits; the forbidden all-ones pattern is the host's
	// to avoid, the logic just takes what is written.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			xover <= 3'h0;
		end else if (wr_ind) begin
			xover <= mgmt_wdata[15:13];
		end
	end

	// The strap is caught while reset is held, not from the pin later on,
	// so a pin that moves in service cannot flip the crossover.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strap_q <= crossover_strap;
		end
	end

	// Mask bits, all masked after reset; the next value also feeds the
	// interrupt so a mask write takes effect in step with the register.
	assign next_mask = wr_mask ?
		mgmt_wdata[phy_regs_pkg::FLAG_MSB:phy_regs_pkg::FLAG_LSB] : mask;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mask <= phy_regs_pkg::MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	// Stored but meaningless bits of the special status register.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			keep_bits <= phy_regs_pkg::KEEP_RESET;
		end else if (wr_status) begin
			keep_bits <= mgmt_wdata[phy_regs_pkg::KEEP_MSB:
				phy_regs_pkg::KEEP_LSB];
		end
	end

	// ****************************************************************
	// Interrupt flags
	// ****************************************************************
	// A live event beats the read clear, so nothing arriving during the
	// read is lost.
	assign next_flags = flag_events | (rd_flags ? 7'h00 : flags);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags <= 7'h00;
		end else begin
			flags <= next_flags;
		end
	end

	// Registered interrupt output, built from the next flags and next mask
	// so it always agrees with what the two registers hold.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_flags & next_mask);
		end
	end

	// ****************************************************************
	// Crossover and mode outputs
	// ****************************************************************
	// Override picks the source; swap only counts in manual crossover.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			auto_crossover <= 1'b0;
			transmit_pair_oe <= 1'b1;
			receive_pair_oe <= 1'b0;
		end else if (xover[phy_regs_pkg::OVERRIDE_BIT]) begin
			auto_crossover <= xover[phy_regs_pkg::AUTO_BIT];
			transmit_pair_oe <= xover[phy_regs_pkg::AUTO_BIT] ||
				!xover[phy_regs_pkg::STATE_BIT];
			receive_pair_oe <= !xover[phy_regs_pkg::AUTO_BIT] &&
				xover[phy_regs_pkg::STATE_BIT];
		end else begin
			auto_crossover <= strap_q;
			transmit_pair_oe <= 1'b1;
			receive_pair_oe <= 1'b0;
		end
	end

	// Registered copies of the decoded mode defaults.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_default <= phy_regs_pkg::CTRL_ANEG;
			adv_default <= phy_regs_pkg::ADV_ALL;
			aneg_enable <= 1'b1;
			crs_on_tx <= 1'b1;
			repeater <= 1'b0;
			ten_base <= 1'b0;
		end else begin
			ctrl_default <= mode_bus.ctrl_default;
			adv_default <= mode_bus.adv_default;
			aneg_enable <= mode_bus.aneg_enable;
			crs_on_tx <= mode_bus.crs_on_tx;
			repeater <= mode_bus.repeater;
			ten_base <= mode_bus.ten_base;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Read data is formed here and registered; unmapped indices read zero.
	always_comb begin
		next_rdata = 16'h0000;
		case (mgmt_index)
			phy_regs_pkg::IDX_SPECIAL_MODES: begin
				next_rdata[phy_regs_pkg::MODE_MSB:phy_regs_pkg::MODE_LSB] = mode;
				next_rdata[4:0] = phy_addr;
			end
			phy_regs_pkg::IDX_BAD_SYMBOL: begin
				next_rdata = tally;
			end
			phy_regs_pkg::IDX_SPECIAL_IND: begin
				next_rdata[15:13] = xover;
				next_rdata[phy_regs_pkg::POLARITY_BIT] =
					rx_polarity_reversed;
			end
			phy_regs_pkg::IDX_FLAGS: begin
				next_rdata[phy_regs_pkg::FLAG_MSB:phy_regs_pkg::FLAG_LSB] =
					flags;
			end
			phy_regs_pkg::IDX_MASK: begin
				next_rdata[phy_regs_pkg::FLAG_MSB:phy_regs_pkg::FLAG_LSB] = mask;
			end
			phy_regs_pkg::IDX_SPECIAL_STATUS: begin
				next_rdata[phy_regs_pkg::AUTODONE_BIT] =
					aneg_done && mode_bus.aneg_enable;
				next_rdata[phy_regs_pkg::KEEP_MSB:phy_regs_pkg::KEEP_LSB] =
					keep_bits;
				next_rdata[phy_regs_pkg::SPEED_MSB:phy_regs_pkg::SPEED_LSB] =
					resolved_speed_duplex;
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// Read answer lands one cycle after the strobe.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mgmt_rdata <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else begin
			mgmt_rvalid <= mgmt_read;
			if (mgmt_read) begin
				mgmt_rdata <= next_rdata;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	irq_follows_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 irq == |(flags & mask))
		else $error("Interrupt does not follow enabled flags.");
	flag_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		flag_events != 7'h00 |=>
		(flags & $past(flag_events)) == $past(flag_events))
		else $error("An event did not latch its flag.");
	flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		flags[7] && !rd_flags |=> flags[7])
		else $error("Energy flag dropped without a read.");
	read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_flags && flag_events == 7'h00 |=> flags == 7'h00)
		else $error("Flag read did not clear idle flags.");
	autodone_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mgmt_read && mgmt_index == phy_regs_pkg::IDX_SPECIAL_STATUS &&
		!mode_bus.aneg_enable |=> !mgmt_rdata[12])
		else $error("Done bit set with autonegotiation off.");
	manual_swap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		xover == 3'h5 ##1 xover == 3'h5 |-> receive_pair_oe &&
		!transmit_pair_oe)
		else $error("Manual swap not applied to pair directions.");
	strap_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!xover[15] |=> auto_crossover == strap_q)
		else $error("Crossover ignores the strap.");
	mode_ten_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode == 3'h1 |=> ctrl_default == 3'h1 && !aneg_enable)
		else $error("Mode 001 defaults wrong.");
endmodule : phy_vendor_status_regs
`default_nettype wire

/* File: verilog/phy_regs_pkg.sv */
// Register indices, field positions, reset values and mode codes of the
// vendor status register bank.
// Assumes a management port that carries five-bit register indices.
package phy_regs_pkg;
	// ****************************************************************
	// Register indices
	// ****************************************************************
	localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
	localparam logic [4:0] IDX_BAD_SYMBOL = 5'h1A;
	localparam logic [4:0] IDX_SPECIAL_IND = 5'h1B;
	localparam logic [4:0] IDX_FLAGS = 5'h1D;
	localparam logic [4:0] IDX_MASK = 5'h1E;
	localparam logic [4:0] IDX_SPECIAL_STATUS = 5'h1F;
	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int MODE_LSB = 5;
	localparam int MODE_MSB = 7;
	localparam logic [2:0] MODE_RESET = 3'h7;
	localparam logic [4:0] PHY_ADDR_RESET = 5'h01;
	localparam int OVERRIDE_BIT = 15;
	localparam int AUTO_BIT = 14;
	localparam int STATE_BIT = 13;
	localparam int POLARITY_BIT = 4;
	localparam int FLAG_MSB = 7;
	localparam int FLAG_LSB = 1;
	localparam logic [6:0] MASK_RESET = 7'h00;
	localparam int AUTODONE_BIT = 12;
	localparam int KEEP_LSB = 5;
	localparam int KEEP_MSB = 11;
	localparam logic [6:0] KEEP_RESET = 7'h02;
	localparam int SPEED_LSB = 2;
	localparam int SPEED_MSB = 4;
	localparam logic [15:0] TALLY_RESET = 16'h0000;
	// ****************************************************************
	// Mode codes and their defaults
	// ****************************************************************
	localparam logic [2:0] MODE_10_HALF = 3'h0;
	localparam logic [2:0] MODE_10_FULL = 3'h1;
	localparam logic [2:0] MODE_100_HALF = 3'h2;
	localparam logic [2:0] MODE_100_FULL = 3'h3;
	localparam logic [2:0] MODE_ADV_100_HALF = 3'h4;
	localparam logic [2:0] MODE_REPEATER = 3'h5;
	localparam logic [2:0] MODE_ALL = 3'h7;
	// Control defaults in order speed, auto-negotiation, duplex.
	localparam logic [2:0] CTRL_10_HALF = 3'h0;
	localparam logic [2:0] CTRL_10_FULL = 3'h1;
	localparam logic [2:0] CTRL_100_HALF = 3'h4;
	localparam logic [2:0] CTRL_100_FULL = 3'h5;
	localparam logic [2:0] CTRL_ANEG = 3'h6;
	localparam logic [3:0] ADV_NONE = 4'h0;
	localparam logic [3:0] ADV_100_HALF = 4'h4;
	localparam logic [3:0] ADV_ALL = 4'hF;
endpackage : phy_regs_pkg

/* File: verilog/phy_mode_if.sv */
// Carries the mode field and its decoded defaults between the register
// bank and the mode decoder.
// Assumes both ends sit in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
interface phy_mode_if;
	logic [2:0] mode;
	logic [2:0] ctrl_default;
	logic [3:0] adv_default;
	logic aneg_enable;
	logic crs_on_tx;
	logic repeater;
	logic ten_base;
	modport decoder (input mode, output ctrl_default, output adv_default,
		output aneg_enable, output crs_on_tx, output repeater,
		output ten_base);
	modport user (output mode, input ctrl_default, input adv_default,
		input aneg_enable, input crs_on_tx, input repeater,
		input ten_base);
endinterface : phy_mode_if
`default_nettype wire

/* File: verilog/phy_mode_decode.sv */
// Decodes the three-bit operating mode into control and advertisement
// defaults.
// Assumes the mode field is held stable by the register bank.
`timescale 1ns/10ps
`default_nettype none
module phy_mode_decode (
	phy_mode_if.decoder cfg
);
	// ****************************************************************
	// Decode
	// ****************************************************************
	// Returns {ctrl, adv, aneg, crs_tx, repeater, ten_base}.
	function automatic logic [10:0] decode_mode(input logic [2:0] m);
		logic [10:0] r;
		r = {phy_regs_pkg::CTRL_ANEG, phy_regs_pkg::ADV_ALL, 4'hA};
		case (m)
			phy_regs_pkg::MODE_10_HALF: r = {phy_regs_pkg::CTRL_10_HALF,
				phy_regs_pkg::ADV_NONE, 4'h5};
			phy_regs_pkg::MODE_10_FULL: r = {phy_regs_pkg::CTRL_10_FULL,
				phy_regs_pkg::ADV_NONE, 4'h1};
			phy_regs_pkg::MODE_100_HALF: r = {phy_regs_pkg::CTRL_100_HALF,
				phy_regs_pkg::ADV_NONE, 4'h4};
			phy_regs_pkg::MODE_100_FULL: r = {phy_regs_pkg::CTRL_100_FULL,
				phy_regs_pkg::ADV_NONE, 4'h0};
			phy_regs_pkg::MODE_ADV_100_HALF: r = {phy_regs_pkg::CTRL_ANEG,
				phy_regs_pkg::ADV_100_HALF, 4'hC};
			phy_regs_pkg::MODE_REPEATER: r = {phy_regs_pkg::CTRL_ANEG,
				phy_regs_pkg::ADV_100_HALF, 4'hA};
			default: r = {phy_regs_pkg::CTRL_ANEG,
				phy_regs_pkg::ADV_ALL, 4'hC};
		endcase
		return r;
	endfunction : decode_mode

	// The reserved code falls into the all-capable branch so it does no harm.
	assign {cfg.ctrl_default, cfg.adv_default, cfg.aneg_enable,
		cfg.crs_on_tx, cfg.repeater, cfg.ten_base} = decode_mode(cfg.mode);
endmodule : phy_mode_decode
`default_nettype wire

/* File: verilog/phy_bad_symbol_counter.sv */
// Counts invalid received code symbols, once per packet at most.
// Assumes symbol and packet indications are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module phy_bad_symbol_counter #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic symbol_invalid,
	input wire logic in_packet,
	input wire logic ten_base,
	output logic [WIDTH-1:0] tally
);
	logic counted;
	logic hit;

	generate
		if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
			$error("phy_bad_symbol_counter: WIDTH must lie in 2..32.");
		end
	endgenerate

	// ****************************************************************
	// Counting
	// ****************************************************************
	// Idle errors count each time; a packet counts only its first error.
	assign hit = symbol_invalid && !ten_base &&
		!(in_packet && counted);

	// Remembers that this packet has already been counted.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !in_packet) begin
			counted <= 1'b0;
		end else if (hit) begin
			counted <= 1'b1;
		end
	end

	// Plain binary add, so the top value rolls over to zero.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tally <= '0;
		end else if (hit) begin
			tally <= tally + 1'b1;
		end
	end

	count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hit |=> tally == $past(tally) + 1'b1)
		else $error("Tally did not advance by one.");
	no_ten_base_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ten_base |=> $stable(tally))
		else $error("Tally moved in 10BASE-T.");
	once_packet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(in_packet && hit) ##1 in_packet |=> $stable(tally))
		else $error("Tally moved twice in one packet.");
endmodule : phy_bad_symbol_counter
`default_nettype wire

/* File: test/mgmt_host_model.sv */
// Station management host model that issues register writes and reads.
// Assumes the register bank samples its strobes on the rising sys_clk edge.
`timescale 1ns/10ps
`default_nettype none
module mgmt_host_model (
	input wire logic sys_clk,
	output logic [4:0] mgmt_index,
	output logic mgmt_write,
	output logic mgmt_read,
	output logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rvalid
);
	// ****************************************************************
	// Idle state and transfers
	// ****************************************************************
	// Strobes are idle from time zero; every change lands on a falling edge.
	initial begin
		mgmt_index = 5'h00;
		mgmt_write = 1'b0;
		mgmt_read = 1'b0;
		mgmt_wdata = 16'h0000;
	end

	// One-cycle write; forbidden codes are repaired before they go out.
	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (idx == phy_regs_pkg::IDX_SPECIAL_MODES && v[7:5] == 3'h6)
			v[7:5] = 3'h7;
		if (idx == phy_regs_pkg::IDX_SPECIAL_IND && v[14])
			v[13] = 1'b0;
		if (idx == phy_regs_pkg::IDX_SPECIAL_STATUS)
			v[11:5] = 7'h02;
		@(negedge sys_clk);
		mgmt_index = idx;
		mgmt_wdata = v;
		mgmt_write = 1'b1;
		@(negedge sys_clk);
		mgmt_write = 1'b0;
	endtask : wr

	// One-cycle read; the word is taken while the valid pulse stands.
	task automatic rd(input logic [4:0] idx, output logic [15:0] d,
		output logic ok);
		ok = 1'b0;
		d = 16'h0000;
		@(negedge sys_clk);
		mgmt_index = idx;
		mgmt_read = 1'b1;
		@(negedge sys_clk);
		mgmt_read = 1'b0;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (mgmt_rvalid === 1'b1) begin
				d = mgmt_rdata;
				ok = 1'b1;
			end else
				@(negedge sys_clk);
		end
	endtask : rd
endmodule : mgmt_host_model
`default_nettype wire

/* File: test/phy_vendor_status_regs_tb.sv */
// Self-checking bench for the vendor status register bank.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module phy_vendor_status_regs_tb;
	logic sys_clk, rst_n, mgmt_write, mgmt_read, mgmt_rvalid;
	logic [4:0] mgmt_index;
	logic [15:0] mgmt_wdata, mgmt_rdata, d;
	logic crossover_strap, symbol_invalid, in_packet, rx_polarity_reversed;
	logic [7:1] flag_events;
	logic aneg_done, aneg_enable, crs_on_tx, repeater, ten_base, irq, ok;
	logic [2:0] resolved_speed_duplex, ctrl_default;
	logic [3:0] adv_default;
	logic auto_crossover, transmit_pair_oe, receive_pair_oe;
	logic [6:0] ev, m;
	logic [2:0] sdv[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
	int xc[4] = '{4, 5, 6, 0};
	int error_cnt = 0;
	int cmp_count = 0;
	int k, t;

	phy_vendor_status_regs #(.TALLY_WIDTH(16)) phy_vendor_status_regs_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .mgmt_index(mgmt_index),
		.mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .crossover_strap(crossover_strap),
		.symbol_invalid(symbol_invalid), .in_packet(in_packet),
		.rx_polarity_reversed(rx_polarity_reversed),
		.flag_events(flag_events), .aneg_done(aneg_done),
		.resolved_speed_duplex(resolved_speed_duplex),
		.ctrl_default(ctrl_default), .adv_default(adv_default),
		.aneg_enable(aneg_enable), .crs_on_tx(crs_on_tx),
		.repeater(repeater), .ten_base(ten_base),
		.auto_crossover(auto_crossover),
		.transmit_pair_oe(transmit_pair_oe),
		.receive_pair_oe(receive_pair_oe), .irq(irq));
	mgmt_host_model host_i (.sys_clk(sys_clk), .mgmt_index(mgmt_index),
		.mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid));

	// ****************************************************************
	// Expectations, comparisons and closing
	// ****************************************************************
	// Mode defaults as {ctrl, adv, aneg, carrier on transmit, rep, ten}.
	function automatic logic [10:0] exp_mode(input logic [2:0] md);
		case (md)
			3'h0: return {3'h0, 4'h0, 4'h5};
			3'h1: return {3'h1, 4'h0, 4'h1};
			3'h2: return {3'h4, 4'h0, 4'h4};
			3'h3: return {3'h5, 4'h0, 4'h0};
			3'h4: return {3'h6, 4'h4, 4'hC};
			3'h5: return {3'h6, 4'h4, 4'hA};
			default: return {3'h6, 4'hF, 4'hC};
		endcase
	endfunction : exp_mode

	// Crossover outputs {automatic, transmit oe, receive oe}; strap was 1.
	function automatic logic [2:0] exp_xo(input logic [2:0] c);
		case (c)
			3'h4: return 3'b010;
			3'h5: return 3'b001;
			default: return 3'b110;
		endcase
	endfunction : exp_xo

	// The verdict is printed in one place only.
	task automatic close_out();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	// Word compare; case inequality keeps unknowns from matching.
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
		input string s);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk_word

	// Single output level compare.
	task automatic chk_bit(input logic got, input logic exp, input string s);
		chk_word({15'h0, got}, {15'h0, exp}, s);
	endtask : chk_bit

	// Register read compared under a mask; a missing answer ends the run.
	task automatic rdc(input logic [4:0] idx, input logic [15:0] exp,
		input logic [15:0] msk);
		host_i.rd(idx, d, ok);
		if (!ok) begin
			error_cnt++;
			$display("mismatch at %0t: no read answer", $time);
			close_out();
		end
		chk_word(d & msk, exp & msk, "register word");
	endtask : rdc

	// Mode write, then time for the decoded defaults to settle.
	task automatic setmode(input logic [2:0] md);
		host_i.wr(phy_regs_pkg::IDX_SPECIAL_MODES, {8'h00, md, 5'h01});
		repeat (3) @(negedge sys_clk);
	endtask : setmode

	// Run of invalid symbols, optionally wrapped in one packet.
	task automatic burst(input int n, input logic pkt);
		@(negedge sys_clk);
		in_packet = pkt;
		symbol_invalid = 1'b1;
		repeat (n) @(negedge sys_clk);
		symbol_invalid = 1'b0;
		in_packet = 1'b0;
	endtask : burst

	// ****************************************************************
	// Clock and main sequence
	// ****************************************************************
	// Free-running 200 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Scenarios run in order; random values come from one fixed seed.
	initial begin
		rst_n = 1'b0;
		crossover_strap = 1'b1;
		symbol_invalid = 1'b0;
		in_packet = 1'b0;
		rx_polarity_reversed = 1'b0;
		flag_events = 7'h00;
		aneg_done = 1'b0;
		resolved_speed_duplex = 3'h1;
		k = $urandom(32'hBDA3);
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		crossover_strap = 1'b0;
		rdc(phy_regs_pkg::IDX_SPECIAL_MODES, 16'h00E1, 16'h00FF);
		rdc(phy_regs_pkg::IDX_BAD_SYMBOL, 16'h0000, 16'hFFFF);
		rdc(phy_regs_pkg::IDX_MASK, 16'h0000, 16'h00FE);
		chk_bit(auto_crossover, 1'b1, "strap");
		host_i.wr(5'h1C, 16'hFFFF);
		rdc(5'h1C, 16'h0000, 16'hFFFF);
		for (int md = 0; md < 8; md++) begin
			setmode(3'(md));
			chk_word({5'h0, ctrl_default, adv_default, aneg_enable,
				crs_on_tx, repeater, ten_base}, {5'h0, exp_mode(3'(md))},
				"mode");
		end
		setmode(phy_regs_pkg::MODE_100_HALF);
		k = $urandom_range(8, 1);
		burst(k, 1'b0);
		burst(5, 1'b1);
		burst(3, 1'b1);
		t = k + 2;
		rdc(phy_regs_pkg::IDX_BAD_SYMBOL, 16'(t), 16'hFFFF);
		rdc(phy_regs_pkg::IDX_BAD_SYMBOL, 16'(t), 16'hFFFF);
		setmode(phy_regs_pkg::MODE_10_HALF);
		burst(4, 1'b0);
		rdc(phy_regs_pkg::IDX_BAD_SYMBOL, 16'(t), 16'hFFFF);
		setmode(phy_regs_pkg::MODE_100_HALF);
		burst(65536 - t, 1'b0);
		rdc(phy_regs_pkg::IDX_BAD_SYMBOL, 16'h0000, 16'hFFFF);
		foreach (xc[i]) begin
			host_i.wr(phy_regs_pkg::IDX_SPECIAL_IND, {3'(xc[i]), 13'h0});
			rx_polarity_reversed = 1'($urandom);
			repeat (2) @(negedge sys_clk);
			chk_word({13'h0, auto_crossover, transmit_pair_oe,
				receive_pair_oe}, {13'h0, exp_xo(3'(xc[i]))},
				"crossover");
			rdc(phy_regs_pkg::IDX_SPECIAL_IND, {3'(xc[i]), 8'h0,
				rx_polarity_reversed, 4'h0}, 16'hE010);
		end
		for (int i = 0; i < 6; i++) begin
			d = 16'($urandom);
			m = d[7:1];
			ev = 7'($urandom_range(127, 1));
			host_i.wr(phy_regs_pkg::IDX_MASK, d);
			rdc(phy_regs_pkg::IDX_MASK, {8'h0, m, 1'b0}, 16'h00FE);
			flag_events = ev;
			@(negedge sys_clk);
			flag_events = 7'h00;
			@(negedge sys_clk);
			chk_bit(irq, |(ev & m), "irq set");
			rdc(phy_regs_pkg::IDX_FLAGS, {8'h0, ev, 1'b0}, 16'h00FF);
			rdc(phy_regs_pkg::IDX_FLAGS, 16'h0000, 16'h00FF);
			chk_bit(irq, 1'b0, "irq clear");
		end
		flag_events = 7'h01;
		rdc(phy_regs_pkg::IDX_FLAGS, 16'h0002, 16'h00FF);
		rdc(phy_regs_pkg::IDX_FLAGS, 16'h0002, 16'h00FF);
		flag_events = 7'h00;
		host_i.wr(phy_regs_pkg::IDX_SPECIAL_STATUS, 16'hFFFF);
		aneg_done = 1'b1;
		for (int j = 0; j < 4; j++) begin
			setmode(j[0] ? 3'h7 : 3'h3);
			resolved_speed_duplex = sdv[j];
			rdc(phy_regs_pkg::IDX_SPECIAL_STATUS, {3'h0, j[0], 7'h0, sdv[j],
				2'h0}, 16'h101C);
		end
		aneg_done = 1'b0;
		rdc(phy_regs_pkg::IDX_SPECIAL_STATUS, 16'h0000, 16'h1000);
		close_out();
	end
endmodule : phy_vendor_status_regs_tb
`default_nettype wire
